/* File: verilog/ctt_defs.vh */
/*
  Constants for the calendar counters and the time-count trim:
  register offsets, field positions, reset values and timebase counts.
  Assumes it is included by bare name from each design file.
*/
`ifndef CTT_DEFS_VH
`define CTT_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CTT_ADDR_DAY        4'h4
`define CTT_ADDR_MONTH      4'h5
`define CTT_ADDR_YEAR       4'h6
`define CTT_ADDR_TRIM       4'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTT_DAY_MSB         5
`define CTT_MONTH_MSB       4
`define CTT_CENTURY_BIT     7
`define CTT_TRIM_SEL_BIT    7
`define CTT_TRIM_DIR_BIT    6
`define CTT_TRIM_MAG_MSB    5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTT_TRIM_RST        8'h00
`define CTT_DAY_RST         6'h01
`define CTT_MONTH_RST       5'h01
`define CTT_YEAR_RST        8'h00
`define CTT_CENTURY_RST     1'b0

// ----------------------------------------------------------------
// Timebase counts
// ----------------------------------------------------------------
`define CTT_SEC_COUNTS      17'h08000
`define CTT_SEC_LAST        16'h7FFF

`endif

/* File: verilog/ctt_trim_divider.v */
/*
  One-second divider with time-count trim, counting oscillator ticks.
  Assumes the seconds counter outside advances on sec_tick and shows
  its new BCD value well before the next oscillator tick.
*/
`include "ctt_defs.vh"
`default_nettype none

module ctt_trim_divider (
  input  wire       clk,
  input  wire       rst,
  input  wire       osc_tick,
  input  wire       sec_restart,
  input  wire       trim_wr,
  input  wire [7:0] trim,
  input  wire [6:0] sec_bcd,
  output reg        sec_tick
);

  reg  [15:0] cnt_q;
  reg         apply_q;
  reg         wr_slot_q;

  wire [5:0]  mag      = trim[`CTT_TRIM_MAG_MSB:0];
  wire        trim_on  = |mag[`CTT_TRIM_MAG_MSB:1];
  wire [6:0]  inc_amt  = {mag - 6'h01, 1'b0};
  wire [6:0]  dec_amt  = {(~mag) + 6'h01, 1'b0};
  wire        instant  = (sec_bcd == 7'h00) ||
                         (!trim[`CTT_TRIM_SEL_BIT] &&
                          (sec_bcd == 7'h20 || sec_bcd == 7'h40));
  reg  [15:0] last_cnt;

  // ----------------------------------------------------------------
  // Terminal count of the running second
  // ----------------------------------------------------------------
  always @* begin
    if (!apply_q || !trim_on) begin
      last_cnt = `CTT_SEC_LAST;
    end else if (trim[`CTT_TRIM_DIR_BIT]) begin
      last_cnt = `CTT_SEC_LAST - {9'h000, dec_amt};
    end else begin
      last_cnt = `CTT_SEC_LAST + {9'h000, inc_amt};
    end
  end

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Greater-or-equal so a trim write that cancels a lengthening past 7FFF still ends the second.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q     <= 16'h0000;
      apply_q   <= 1'b0;
      wr_slot_q <= 1'b0;
      sec_tick  <= 1'b0;
    end else begin
      sec_tick <= 1'b0;
      if (sec_restart) begin
        cnt_q     <= 16'h0000;
        wr_slot_q <= trim_wr;
        apply_q   <= 1'b0;
      end else if (osc_tick && cnt_q >= last_cnt) begin
        cnt_q     <= 16'h0000;
        sec_tick  <= 1'b1;
        wr_slot_q <= trim_wr;
        apply_q   <= 1'b0;
      end else if (osc_tick) begin
        cnt_q <= cnt_q + 16'h0001;
        if (trim_wr) begin
          wr_slot_q <= 1'b1;
        end
        // Seconds value has settled by the first tick of the new second
        if (cnt_q == 16'h0000) begin
          apply_q <= instant && !wr_slot_q && !trim_wr;
        end else if (trim_wr) begin
          apply_q <= 1'b0;
        end
      end else if (trim_wr) begin
        wr_slot_q <= 1'b1;
        apply_q   <= 1'b0;
      end
    end
  end

endmodule // ctt_trim_divider

`default_nettype wire

/* File: verilog/ctt_calendar.v */
/*
  Calendar section of the real-time clock: day-of-month, month with
  century flag, year, and the time-count trim register, with the
  one-second timebase driven from the 32.768 kHz oscillator pin.
  Assumes the serial port engine and hour counter run on CLK and
  present register accesses and the hour carry as one-cycle strobes.
*/
`include "ctt_defs.vh"
`default_nettype none

module ctt_calendar (
  input  wire       CLK,
  input  wire       RST,
  input  wire       OSC_32K,
  input  wire       HOUR_CARRY,
  input  wire       SEC_WRITE,
  input  wire [6:0] SEC_BCD,
  input  wire [3:0] REG_ADDR,
  input  wire       REG_WR,
  input  wire [7:0] REG_WDATA,
  output reg  [7:0] REG_RDATA,
  output wire       SEC_TICK,
  output reg        CLK32_OUT,
  output reg        DAY_CARRY,
  output reg  [5:0] DAY_BCD,
  output reg  [4:0] MONTH_BCD,
  output reg  [7:0] YEAR_BCD,
  output reg        CENTURY
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg        osc_s1_q;
  reg        osc_s2_q;
  reg        osc_s3_q;
  reg  [7:0] trim_q;
  wire       osc_tick;
  wire       wr_day;
  wire       wr_month;
  wire       wr_year;
  wire       wr_trim;
  wire       leap;
  wire [5:0] month_end;
  wire       day_wrap;
  wire       month_wrap;
  wire       year_wrap;
  wire [5:0] day_nx;
  wire [4:0] month_nx;
  wire [7:0] year_nx;
  reg  [7:0] rdata_d;

  // ----------------------------------------------------------------
  // BCD helpers
  // ----------------------------------------------------------------
  function is_leap;
    input [7:0] y;
    begin
      // Odd tens digit: units 2 or 6; even tens: units 0, 4 or 8
      if (y[4]) begin
        is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end else begin
        is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                  (y[3:0] == 4'h8);
      end
    end
  endfunction

  function [5:0] last_day;
    input [4:0] mo;
    input       lp;
    begin
      case (mo)
        5'h02: begin
          last_day = lp ? 6'h29 : 6'h28;
        end
        5'h04, 5'h06, 5'h09, 5'h11: begin
          last_day = 6'h30;
        end
        default: begin
          last_day = 6'h31;
        end
      endcase
    end
  endfunction

  function [5:0] day_inc;
    input [5:0] d;
    begin
      if (d[3:0] == 4'h9) begin
        day_inc = {d[5:4] + 2'h1, 4'h0};
      end else begin
        day_inc = {d[5:4], d[3:0] + 4'h1};
      end
    end
  endfunction

  function [4:0] month_inc;
    input [4:0] m;
    begin
      if (m[3:0] == 4'h9) begin
        month_inc = 5'h10;
      end else begin
        month_inc = {m[4], m[3:0] + 4'h1};
      end
    end
  endfunction

  function [7:0] year_inc;
    input [7:0] y;
    begin
      if (y[3:0] != 4'h9) begin
        year_inc = {y[7:4], y[3:0] + 4'h1};
      end else if (y[7:4] == 4'h9) begin
        year_inc = 8'h00;
      end else begin
        year_inc = {y[7:4] + 4'h1, 4'h0};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Oscillator pin: synchroniser and edge
  // ----------------------------------------------------------------
  // Only the second stage and beyond feed logic.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      osc_s1_q  <= 1'b0;
      osc_s2_q  <= 1'b0;
      osc_s3_q  <= 1'b0;
      CLK32_OUT <= 1'b0;
    end else begin
      osc_s1_q  <= OSC_32K;
      osc_s2_q  <= osc_s1_q;
      osc_s3_q  <= osc_s2_q;
      // Taken before the divider, so trim cannot touch it
      CLK32_OUT <= osc_s2_q;
    end
  end

  assign osc_tick = osc_s2_q && !osc_s3_q;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign wr_day   = REG_WR && (REG_ADDR == `CTT_ADDR_DAY);
  assign wr_month = REG_WR && (REG_ADDR == `CTT_ADDR_MONTH);
  assign wr_year  = REG_WR && (REG_ADDR == `CTT_ADDR_YEAR);
  assign wr_trim  = REG_WR && (REG_ADDR == `CTT_ADDR_TRIM);

  // ----------------------------------------------------------------
  // Carry chain
  // ----------------------------------------------------------------
  // Invalid written dates carry unpredictably; host keeps them valid.
  assign leap       = is_leap(YEAR_BCD);
  assign month_end  = last_day(MONTH_BCD, leap);
  assign day_wrap   = (DAY_BCD == month_end);
  assign month_wrap = (MONTH_BCD == 5'h12);
  assign year_wrap  = (YEAR_BCD == 8'h99);
  assign day_nx     = day_wrap ? `CTT_DAY_RST : day_inc(DAY_BCD);
  assign month_nx   = month_wrap ? `CTT_MONTH_RST :
                      month_inc(MONTH_BCD);
  assign year_nx    = year_inc(YEAR_BCD);

  // ----------------------------------------------------------------
  // Calendar and trim registers
  // ----------------------------------------------------------------
  // All carries land on the same edge; a host write in that cycle
  // overrides the carried value of the register it targets.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      DAY_BCD   <= `CTT_DAY_RST;
      MONTH_BCD <= `CTT_MONTH_RST;
      YEAR_BCD  <= `CTT_YEAR_RST;
      CENTURY   <= `CTT_CENTURY_RST;
      trim_q    <= `CTT_TRIM_RST;
      DAY_CARRY <= 1'b0;
    end else begin
      DAY_CARRY <= HOUR_CARRY;
      if (HOUR_CARRY) begin
        DAY_BCD <= day_nx;
        if (day_wrap) begin
          MONTH_BCD <= month_nx;
          if (month_wrap) begin
            YEAR_BCD <= year_nx;
            if (year_wrap) begin
              CENTURY <= !CENTURY;
            end
          end
        end
      end
      if (wr_day) begin
        DAY_BCD <= REG_WDATA[`CTT_DAY_MSB:0];
      end
      if (wr_month) begin
        MONTH_BCD <= REG_WDATA[`CTT_MONTH_MSB:0];
        CENTURY   <= REG_WDATA[`CTT_CENTURY_BIT];
      end
      if (wr_year) begin
        YEAR_BCD <= REG_WDATA;
      end
      if (wr_trim) begin
        trim_q <= REG_WDATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @* begin
    case (REG_ADDR)
      `CTT_ADDR_DAY: begin
        rdata_d = {2'b00, DAY_BCD};
      end
      `CTT_ADDR_MONTH: begin
        rdata_d = {CENTURY, 2'b00, MONTH_BCD};
      end
      `CTT_ADDR_YEAR: begin
        rdata_d = YEAR_BCD;
      end
      `CTT_ADDR_TRIM: begin
        rdata_d = trim_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  ctt_trim_divider u_div (
    .clk         (CLK),
    .rst         (RST),
    .osc_tick    (osc_tick),
    .sec_restart (SEC_WRITE),
    .trim_wr     (wr_trim),
    .trim        (trim_q),
    .sec_bcd     (SEC_BCD),
    .sec_tick    (SEC_TICK)
  );

endmodule // ctt_calendar

`default_nettype wire

/* File: test/ctt_calendar_props.sv */
/*
  Checker for the calendar counters, register read-back and carry chain.
  Assumes it is bound to ctt_calendar and sees only its ports.
*/
`default_nettype none
module ctt_calendar_props (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       OSC_32K,
  input wire logic       HOUR_CARRY,
  input wire logic       SEC_WRITE,
  input wire logic       REG_WR,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_RDATA,
  input wire logic       SEC_TICK,
  input wire logic       CLK32_OUT,
  input wire logic       DAY_CARRY,
  input wire logic [5:0] DAY_BCD,
  input wire logic [4:0] MONTH_BCD,
  input wire logic [7:0] YEAR_BCD,
  input wire logic       CENTURY
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  warm_q;
  logic        osc_prev_q;
  logic [16:0] osc_cnt_q;
  // Cycles since reset, and pin edges since the last second boundary
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      warm_q     <= 2'h0;
      osc_prev_q <= 1'b0;
      osc_cnt_q  <= 17'h00000;
    end else begin
      osc_prev_q <= OSC_32K;
      if (warm_q != 2'h3) warm_q <= warm_q + 2'h1;
      if (SEC_TICK || SEC_WRITE) osc_cnt_q <= 17'h00000;
      else if (OSC_32K && !osc_prev_q && osc_cnt_q != 17'h1FFFF) osc_cnt_q <= osc_cnt_q + 17'h00001;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------
  // Read-back formats
  // ----------------------------------------
  a_day_upper_zero: assert property ($past(REG_ADDR) == 4'h4 |-> REG_RDATA[7:6] == 2'b00)
    else $error("day read shows upper bits");
  a_month_gap_zero: assert property ($past(REG_ADDR) == 4'h5 |-> REG_RDATA[6:5] == 2'b00)
    else $error("month read shows gap bits");
  a_unmapped_reads: assert property ($past(REG_ADDR) < 4'h4 || $past(REG_ADDR) > 4'h7 |-> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  // ----------------------------------------
  // Carry chain
  // ----------------------------------------
  a_day_carry_echo: assert property (DAY_CARRY == $past(HOUR_CARRY))
    else $error("day carry not one cycle after hour carry");
  a_day_plain_step: assert property (HOUR_CARRY && !REG_WR && DAY_BCD < 6'h28 && DAY_BCD[3:0] != 4'h9
    |=> DAY_BCD == $past(DAY_BCD) + 6'h01) else $error("day did not step by one");
  a_year_end_wrap: assert property (HOUR_CARRY && !REG_WR && DAY_BCD == 6'h31 && MONTH_BCD == 5'h12
    |=> DAY_BCD == 6'h01 && MONTH_BCD == 5'h01 && YEAR_BCD != $past(YEAR_BCD)) else $error("year end wrong");
  a_century_flip: assert property (HOUR_CARRY && !REG_WR && DAY_BCD == 6'h31 && MONTH_BCD == 5'h12
    && YEAR_BCD == 8'h99 |=> YEAR_BCD == 8'h00 && CENTURY != $past(CENTURY)) else $error("century not toggled");
  a_date_hold: assert property (!HOUR_CARRY && !REG_WR
    |=> $stable(DAY_BCD) && $stable(MONTH_BCD) && $stable(YEAR_BCD)) else $error("date moved without cause");
  a_date_range: assert property (DAY_BCD != 6'h00 && DAY_BCD <= 6'h31 && MONTH_BCD != 5'h00
    && MONTH_BCD <= 5'h12) else $error("date out of range");
  // Output clock bypasses the trimmed divider
  // Three clean edges after reset before the copy can show the pin
  a_clk32_copy: assert property (warm_q == 2'h3 |-> CLK32_OUT == $past(OSC_32K, 3))
    else $error("clock output not a delayed oscillator copy");
  a_tick_single: assert property (SEC_TICK |=> !SEC_TICK)
    else $error("second tick longer than one cycle");
  // Pin-side count may be one short of the divider's after a restart
  a_second_length: assert property (SEC_TICK |-> osc_cnt_q >= 17'h07F83 && osc_cnt_q <= 17'h0807D)
    else $error("second length outside trim range");
endmodule // ctt_calendar_props
bind ctt_calendar ctt_calendar_props i_props (.CLK(CLK), .RST(RST), .OSC_32K(OSC_32K), .HOUR_CARRY(HOUR_CARRY),
  .SEC_WRITE(SEC_WRITE),
  .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .SEC_TICK(SEC_TICK), .CLK32_OUT(CLK32_OUT),
  .DAY_CARRY(DAY_CARRY), .DAY_BCD(DAY_BCD), .MONTH_BCD(MONTH_BCD), .YEAR_BCD(YEAR_BCD), .CENTURY(CENTURY));
`default_nettype wire

/* File: test/tb_top.sv */
/*
  Self-checking bench for the calendar counters and trim register.
  Assumes one-cycle write and carry strobes and a registered read port.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, osc, hour_carry, sec_write, reg_wr;
  logic [1:0] osc_div;
  logic [6:0] sec_bcd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, year_bcd, y;
  logic       sec_tick, clk32_out, day_carry, century;
  logic [5:0] day_bcd, ld;
  logic [4:0] month_bcd, m, nm;
  int         miscompares, comparisons, ticks;

  ctt_calendar i_dut (.CLK(clk), .RST(rst), .OSC_32K(osc), .HOUR_CARRY(hour_carry), .SEC_WRITE(sec_write),
    .SEC_BCD(sec_bcd), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .SEC_TICK(sec_tick), .CLK32_OUT(clk32_out), .DAY_CARRY(day_carry), .DAY_BCD(day_bcd),
    .MONTH_BCD(month_bcd), .YEAR_BCD(year_bcd), .CENTURY(century));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Slow oscillator, four system clocks per half period
  always @(posedge clk) begin
    osc_div <= rst ? 2'h0 : osc_div + 2'h1;
    if (!rst && osc_div == 2'h3) osc <= ~osc;
  end
  // A second is over 32000 oscillator counts, far longer than this run
  always @(posedge clk) begin
    if (!rst && sec_tick !== 1'b0) ticks++;
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    chk("read data", reg_rdata, exp);
  endtask
  task automatic carry;
    @(posedge clk);
    hour_carry <= 1'b1;
    @(posedge clk);
    hour_carry <= 1'b0;
    #1;
    chk("day carry", {7'h00, day_carry}, 8'h01);
  endtask
  // Leap test in BCD: tens weigh 2 modulo 4
  function automatic logic [5:0] last_day(input logic [4:0] mo, input logic [7:0] yr);
    logic [3:0] s;
    s = yr[3:0] + {2'b00, yr[4], 1'b0};
    if (mo == 5'h02) return (s[1:0] == 2'b00) ? 6'h29 : 6'h28;
    if (mo == 5'h04 || mo == 5'h06 || mo == 5'h09 || mo == 5'h11) return 6'h30;
    return 6'h31;
  endfunction
  task automatic finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    $display("mismatch watchdog expected finish seen timeout");
    finish_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, osc, osc_div, hour_carry, sec_write, reg_wr, sec_bcd, reg_addr, reg_wdata} = {1'b1, 25'h0000000};
    miscompares = 0;
    ticks = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(4'h7, 8'h00);
    $display("test reset done");
    wr(4'h4, 8'hD5);
    rd(4'h4, 8'h15);
    wr(4'h5, 8'hE9);
    rd(4'h5, 8'h89);
    wr(4'h6, 8'h87);
    rd(4'h6, 8'h87);
    wr(4'h7, 8'hC3);
    rd(4'h7, 8'hC3);
    wr(4'h9, 8'h5A);
    rd(4'h9, 8'h00);
    rd(4'h7, 8'hC3);
    $display("test register fields done");
    for (int i = 0; i < 14; i++) begin
      m = (i < 9) ? 5'(i + 1) : (i < 12) ? 5'(i + 7) : 5'h02;
      y = (i == 12) ? 8'h24 : (i == 13) ? 8'h00 : 8'h23;
      ld = last_day(m, y);
      nm = (m == 5'h12) ? 5'h01 : (m == 5'h09) ? 5'h10 : m + 5'h01;
      wr(4'h6, y);
      wr(4'h5, {3'b000, m});
      wr(4'h4, {2'b00, (ld[3:0] == 4'h0) ? ld - 6'h07 : ld - 6'h01});
      carry();
      chk("last day", {2'b00, day_bcd}, {2'b00, ld});
      carry();
      chk("day wrap", {2'b00, day_bcd}, 8'h01);
      chk("month step", {3'b000, month_bcd}, {3'b000, nm});
      chk("year step", year_bcd, (m == 5'h12) ? y + 8'h01 : y);
    end
    $display("test month ends done");
    for (int k = 0; k < 2; k++) begin
      wr(4'h6, 8'h99);
      wr(4'h5, k ? 8'h92 : 8'h12);
      wr(4'h4, 8'h31);
      carry();
      rd(4'h6, 8'h00);
      rd(4'h5, k ? 8'h01 : 8'h81);
      rd(4'h4, 8'h01);
    end
    chk("second tick", (ticks == 0) ? 8'h00 : 8'h01, 8'h00);
    $display("test century done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
